// ===== include/irq_logic_regs.vh
`ifndef IRQ_LOGIC_REGS_VH
`define IRQ_LOGIC_REGS_VH
// Register selects on the core's register port
`define REG_SEL_PENDING 2'h0
`define REG_SEL_ENABLES 2'h1
`define REG_SEL_STATUS0 2'h2
// Field positions
`define GIM_BIT 9
`define NUM_SRC 16
`define IDX_W 4
// Reset values
`define PENDING_RESET 16'h0000
`define ENABLES_RESET 16'h0000
`define STATUS0_RESET 16'h0200
// Vector base in program memory, two words per vector
`define VECTOR_BASE 16'h0000
`define VECTOR_NMI 16'h0024
// Cycles the acknowledge stays up while the vector is fetched
`define ACK_CYCLES 2'h2
`endif

// ===== rtl/irq_priority_pick.v
`timescale 1ns/1ps
`include "irq_logic_regs.vh"
// Lowest set bit wins; combinational picker
module irq_priority_pick (
    input wire [15:0] req_i,
    output reg found_o,
    output reg [3:0] index_o
);
    integer k;
    // Scan from the top so the lowest bit is written last
    always @* begin
        found_o = 1'b0;
        index_o = 4'h0;
        for (k = `NUM_SRC - 1; k >= 0; k = k - 1) begin
            if (req_i[k]) begin
                found_o = 1'b1;
                index_o = k[3:0];
            end
        end
    end
endmodule

// ===== rtl/cpu_interrupt_request_logic.v
`timescale 1ns/1ps
`include "irq_logic_regs.vh"
// Notes on behaviour
// - A 16-bit pending flag register is readable by software.
// - Writing one to a pending bit clears it; zeros leave bits alone.
// - A 16-bit enable register lets each source through when global mode is zero.
// - Bit 9 of the first status register blocks all maskable interrupts when set.
// - The acknowledge output is high while the vector is fetched.
// - On acknowledge, execution is redirected to the source's fixed vector address.
// - Requests come from pins, peripherals and interrupt instructions.
// - The nonmaskable interrupt uses the same acknowledge path and cannot be blocked.
// - A maskable request stays pending until acknowledged.
module cpu_interrupt_request_logic (
    input wire clk_i,
    input wire rst_n_i,
    input wire [15:0] ext_irq_pins_i,
    input wire [15:0] periph_irq_i,
    input wire sw_irq_valid_i,
    input wire [3:0] sw_irq_index_i,
    input wire nmi_pin_i,
    input wire nmi_instr_i,
    input wire cpu_ready_i,
    input wire reg_wr_i,
    input wire [1:0] reg_sel_i,
    input wire [15:0] reg_wdata_i,
    input wire gim_set_i,
    input wire gim_clr_i,
    output reg [15:0] reg_rdata_o,
    output reg [15:0] interrupt_pending_flags_o,
    output reg [15:0] interrupt_source_enables_o,
    output reg global_interrupt_mode_bit_o,
    output reg interrupt_ack_out_o,
    output reg vector_load_o,
    output reg [15:0] vector_addr_o
);
    // Raw asynchronous inputs; the top lane carries the nonmaskable pin
    wire [16:0] raw_in = {nmi_pin_i, ext_irq_pins_i};
    wire [16:0] lvl_all;
    reg [15:0] pin_prev_q;
    reg nmi_prev_q;
    reg [15:0] pending_q, pending_d;
    reg [15:0] enables_q;
    reg [15:0] status0_q;
    reg nmi_pend_q, nmi_pend_d;
    reg [1:0] ack_cnt_q;
    reg ack_busy_q;

    // Only enabled flags compete for service
    wire [15:0] take = pending_q & enables_q;
    wire found;
    wire [3:0] pick_idx;

    irq_priority_pick u_pick (
        .req_i(take),
        .found_o(found),
        .index_o(pick_idx)
    );

    // Address of a vector: two words per slot from the base
    function [15:0] vec_of;
        input [3:0] idx;
        begin
            vec_of = `VECTOR_BASE + {11'h000, idx, 1'b0} + 16'h0002;
        end
    endfunction

    // Write strobe aimed at one register select
    function wr_hit;
        input wr;
        input [1:0] cur;
        input [1:0] sel;
        begin
            wr_hit = wr && (cur == sel);
        end
    endfunction

    wire wr_pending = wr_hit(reg_wr_i, reg_sel_i, `REG_SEL_PENDING);
    wire wr_enables = wr_hit(reg_wr_i, reg_sel_i, `REG_SEL_ENABLES);
    wire wr_status0 = wr_hit(reg_wr_i, reg_sel_i, `REG_SEL_STATUS0);
    wire [15:0] gim_mask = 16'h0001 << `GIM_BIT;

    wire gim = status0_q[`GIM_BIT];
    wire [15:0] pin_rise = lvl_all[15:0] & ~pin_prev_q;
    wire nmi_rise = lvl_all[16] & ~nmi_prev_q;
    // Nonmaskable goes first; a busy acknowledge holds off every new accept
    wire accept_nmi = !ack_busy_q && cpu_ready_i && nmi_pend_q;
    wire accept_mask = !ack_busy_q && cpu_ready_i && !nmi_pend_q && found && !gim;
    wire accept_any = accept_nmi || accept_mask;
    // Mode bit forced on by a set or an accept in the same cycle as a status write
    wire [15:0] gim_force = (gim_set_i || accept_any) ? gim_mask : 16'h0000;

    // Three synchroniser flip-flops plus a level flip-flop per lane; a change counts once stages two and three agree,
    // so a level seen at only one clock edge never reaches the flags
    genvar g;
    generate
        for (g = 0; g < `NUM_SRC + 1; g = g + 1) begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg lvl_q;
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    s1_q <= raw_in[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign lvl_all[g] = lvl_q;
        end
    endgenerate

    // Previous filtered levels; reset low matches idle pins, so no false edge follows
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_prev_q <= 16'h0000;
            nmi_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= lvl_all[15:0];
            nmi_prev_q <= lvl_all[16];
        end
    end

    // Pending flags: sets win over software clear and acknowledge clear
    always @* begin
        pending_d = pending_q;
        if (wr_pending) begin
            pending_d = pending_d & ~reg_wdata_i;
        end
        if (accept_mask) begin
            pending_d[pick_idx] = 1'b0;
        end
        // Held until acknowledged; no mask gating on capture
        pending_d = pending_d | pin_rise | periph_irq_i;
        if (sw_irq_valid_i) begin
            pending_d[sw_irq_index_i] = 1'b1;
        end
        // Nonmaskable request: acknowledge clears, a new edge or instruction sets
        nmi_pend_d = nmi_pend_q;
        if (accept_nmi) begin
            nmi_pend_d = 1'b0;
        end
        if (nmi_rise || nmi_instr_i) begin
            nmi_pend_d = 1'b1;
        end
    end

    // Register state and acknowledge sequencing
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_q <= `PENDING_RESET;
            enables_q <= `ENABLES_RESET;
            status0_q <= `STATUS0_RESET;
            nmi_pend_q <= 1'b0;
            ack_cnt_q <= 2'h0;
            ack_busy_q <= 1'b0;
        end else begin
            pending_q <= pending_d;
            nmi_pend_q <= nmi_pend_d;
            if (wr_enables) begin
                enables_q <= reg_wdata_i;
            end
            if (wr_status0) begin
                // A set in the same cycle as a software write still wins
                status0_q <= reg_wdata_i | gim_force;
            end else if (gim_set_i || accept_any) begin
                // Entering a service routine masks further maskable requests
                status0_q[`GIM_BIT] <= 1'b1;
            end else if (gim_clr_i) begin
                status0_q[`GIM_BIT] <= 1'b0;
            end
            // Acknowledge window: the counter runs down while the vector is fetched
            if (accept_any) begin
                ack_busy_q <= 1'b1;
                ack_cnt_q <= `ACK_CYCLES;
            end else if (ack_busy_q) begin
                ack_cnt_q <= ack_cnt_q - 2'h1;
                if (ack_cnt_q == 2'h1) begin
                    ack_busy_q <= 1'b0;
                end
            end
        end
    end

    // Registered outputs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
            interrupt_pending_flags_o <= `PENDING_RESET;
            interrupt_source_enables_o <= `ENABLES_RESET;
            global_interrupt_mode_bit_o <= 1'b1;
            interrupt_ack_out_o <= 1'b0;
            vector_load_o <= 1'b0;
            vector_addr_o <= 16'h0000;
        end else begin
            // Read data lags the select by one clock
            case (reg_sel_i)
                `REG_SEL_PENDING: reg_rdata_o <= pending_q;
                `REG_SEL_ENABLES: reg_rdata_o <= enables_q;
                `REG_SEL_STATUS0: reg_rdata_o <= status0_q;
                default: reg_rdata_o <= 16'h0000;
            endcase
            interrupt_pending_flags_o <= pending_q;
            interrupt_source_enables_o <= enables_q;
            global_interrupt_mode_bit_o <= gim;
            interrupt_ack_out_o <= accept_nmi || accept_mask || (ack_busy_q && ack_cnt_q != 2'h1);
            vector_load_o <= accept_nmi || accept_mask;
            // Address holds between accepts for a late re-fetch
            if (accept_nmi) begin
                vector_addr_o <= `VECTOR_NMI;
            end else if (accept_mask) begin
                vector_addr_o <= vec_of(pick_idx);
            end
        end
    end
endmodule

// ===== tb/cpu_sequencer_model.sv
`timescale 1ns/1ps
// Sequencer stand-in: says when an interrupt may be taken
module cpu_sequencer_model (
    input wire clk_i,
    input wire rst_n_i,
    input wire slow_i,
    output reg cpu_ready_o
);
    // Slow mode mimics multi-cycle instructions: ready every other cycle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_ready_o <= 1'b0;
        end else begin
            cpu_ready_o <= slow_i ? ~cpu_ready_o : 1'b1;
        end
    end
endmodule

// ===== tb/irq_logic_assertions.sv
`timescale 1ns/1ps
module irq_logic_assertions (
    input wire clk_i,
    input wire rst_n_i,
    input wire nmi_instr_i,
    input wire reg_wr_i,
    input wire [1:0] reg_sel_i,
    input wire [15:0] reg_wdata_i,
    input wire gim_set_i,
    input wire gim_clr_i,
    input wire [15:0] interrupt_source_enables_o,
    input wire global_interrupt_mode_bit_o,
    input wire interrupt_ack_out_o,
    input wire vector_load_o,
    input wire [15:0] vector_addr_o
);
    // Short aliases keep each property on one line
    wire ack = interrupt_ack_out_o;
    wire vl = vector_load_o;
    wire [15:0] va = vector_addr_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ack_tail; ack ##1 !ack; endsequence
    sequence s_gap; !vl ##1 !vl; endsequence
    property p_ack2; $rose(ack) |=> s_ack_tail; endproperty
    a_ack2: assert property (p_ack2) else $error("ack width wrong");
    property p_vl_first; vl |-> $rose(ack); endproperty
    a_vl_first: assert property (p_vl_first) else $error("load not on ack rise");
    property p_gap; vl |=> s_gap; endproperty
    a_gap: assert property (p_gap) else $error("accepts too close");
    property p_addr; vl |-> va == 16'h0024 || (!va[0] && va >= 16'h0002 && va <= 16'h0020); endproperty
    a_addr: assert property (p_addr) else $error("vector address off");
    property p_hold; !vl |-> $stable(va); endproperty
    a_hold: assert property (p_hold) else $error("vector moved");
    property p_enw; reg_wr_i && reg_sel_i == 2'h1 |-> ##2 interrupt_source_enables_o == $past(reg_wdata_i, 2); endproperty
    a_enw: assert property (p_enw) else $error("enable write lost");
    property p_gim; gim_set_i && !gim_clr_i && !reg_wr_i |-> ##2 global_interrupt_mode_bit_o; endproperty
    a_gim: assert property (p_gim) else $error("mode bit not set");
    property p_nmi; nmi_instr_i |-> ##[1:16] vl && va == 16'h0024; endproperty
    a_nmi: assert property (p_nmi) else $error("nonmaskable not served");
endmodule
bind cpu_interrupt_request_logic irq_logic_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .nmi_instr_i(nmi_instr_i), .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i),
    .reg_wdata_i(reg_wdata_i), .gim_set_i(gim_set_i), .gim_clr_i(gim_clr_i),
    .interrupt_source_enables_o(interrupt_source_enables_o),
    .global_interrupt_mode_bit_o(global_interrupt_mode_bit_o),
    .interrupt_ack_out_o(interrupt_ack_out_o), .vector_load_o(vector_load_o),
    .vector_addr_o(vector_addr_o));

// ===== tb/cpu_interrupt_request_logic_test.sv
`timescale 1ns/1ps
module cpu_interrupt_request_logic_test;
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg sw_v = 1'b0, nmi = 1'b0, wr = 1'b0, gs = 1'b0, gc = 1'b0, slow = 1'b0;
    reg [3:0] sw_x = 4'h0, a, b;
    reg [1:0] sel = 2'h0;
    reg [15:0] wd = 16'h0000, r;
    reg [15:0] pins = 16'h0000, per = 16'h0000;
    reg nmip = 1'b0;
    wire rdy, ack, vl, gim;
    wire [15:0] rd, pend, ena, va;
    integer err_total = 0, check_count = 0, cyc = 0, t = 0, i;
    always #20 clk_i = ~clk_i;
    cpu_sequencer_model partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .cpu_ready_o(rdy));
    cpu_interrupt_request_logic dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .ext_irq_pins_i(pins), .periph_irq_i(per), .sw_irq_valid_i(sw_v),
        .sw_irq_index_i(sw_x), .nmi_pin_i(nmip), .nmi_instr_i(nmi), .cpu_ready_i(rdy),
        .reg_wr_i(wr), .reg_sel_i(sel), .reg_wdata_i(wd), .gim_set_i(gs), .gim_clr_i(gc),
        .reg_rdata_o(rd), .interrupt_pending_flags_o(pend),
        .interrupt_source_enables_o(ena), .global_interrupt_mode_bit_o(gim),
        .interrupt_ack_out_o(ack), .vector_load_o(vl), .vector_addr_o(va));
    // Vector slot of a maskable source, two words each
    function [15:0] vec(input [3:0] x);
        vec = 16'h0002 + {11'h000, x, 1'b0};
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Inputs always move 2 ns after the rising edge
    task step(input integer n);
        begin
            repeat (n) @(posedge clk_i);
            #2;
        end
    endtask
    task tdone;
        begin
            t = t + 1;
            $display("test %0d done", t);
        end
    endtask
    task wr_reg(input [1:0] s, input [15:0] d);
        begin
            wr = 1'b1;
            sel = s;
            wd = d;
            step(1);
            wr = 1'b0;
            step(3);
        end
    endtask
    task sw(input [3:0] x);
        begin
            sw_v = 1'b1;
            sw_x = x;
            step(1);
            sw_v = 1'b0;
            step(3);
        end
    endtask
    // Bounded wait for the one-cycle load pulse
    task wait_vec(input [15:0] exp);
        begin
            i = 0;
            while (vl !== 1'b1 && i < 20) begin
                step(1);
                i = i + 1;
            end
            chk({15'h0000, ack}, 16'h0001);
            chk(va, exp);
            step(4);
        end
    endtask
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            err_total = err_total + 1;
            results;
        end
    end
    initial begin
        r = $urandom(97);
        step(5);
        rst_n_i = 1'b1;
        step(2);
        chk(pend, 16'h0000);
        chk({15'h0000, gim}, 16'h0001);
        tdone;
        r = $urandom;
        wr_reg(2'h1, r);
        chk(rd, r);
        tdone;
        a = $urandom;
        a[3] = 1'b0;
        b = a | 4'h8;
        gs = 1'b1;
        step(1);
        gs = 1'b0;
        wr_reg(2'h1, 16'hffff);
        sw(a);
        chk(pend, 16'h0001 << a);
        wr_reg(2'h0, ~(16'h0001 << a));
        chk(pend, 16'h0001 << a);
        sw(b);
        tdone;
        gc = 1'b1;
        step(1);
        gc = 1'b0;
        wait_vec(vec(a));
        chk(pend, 16'h0001 << b);
        wr_reg(2'h0, 16'h0001 << b);
        chk(pend, 16'h0000);
        tdone;
        wr_reg(2'h1, 16'h0000);
        slow = 1'b1;
        nmi = 1'b1;
        step(1);
        nmi = 1'b0;
        wait_vec(16'h0024);
        tdone;
        // Peripheral level and a pin edge both land as flags while masked
        slow = 1'b0;
        wr_reg(2'h1, 16'h0100);
        sel = 2'h0;
        per = 16'h0001 << a;
        pins = 16'h0100;
        step(1);
        per = 16'h0000;
        step(8);
        chk(rd, 16'h0100 | (16'h0001 << a));
        chk(pend, 16'h0100 | (16'h0001 << a));
        sel = 2'h2;
        step(2);
        chk(rd, 16'h0001 << 9);
        tdone;
        // Only the enabled source is taken; the disabled one keeps its flag
        gc = 1'b1;
        step(1);
        gc = 1'b0;
        wait_vec(vec(4'h8));
        chk(pend, 16'h0001 << a);
        pins = 16'h0000;
        nmip = 1'b1;
        wait_vec(16'h0024);
        nmip = 1'b0;
        wr_reg(2'h0, 16'h0001 << a);
        chk(pend, 16'h0000);
        tdone;
        results;
    end
endmodule
